// ### mcuid_pkg.sv
`default_nettype none
package mcuid_pkg;
    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_PSA_BIT = 1;
    localparam int CTRL_WAKE_BIT = 2;
    localparam logic CTRL_RUN_RESET = 1'h0;
    localparam logic CTRL_PSA_RESET = 1'h0;
    localparam logic TIMEOUT_RESET = 1'h1;
    localparam logic POWERDOWN_N_RESET = 1'h1;
    localparam logic [12:0] PC_RESET = 13'h0000;
    // ------------------------------------------------------------
    // file map and core sizes
    // ------------------------------------------------------------
    localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
    localparam logic [6:0] PORT_ADDR = 7'h06;
    localparam int FILE_DEPTH = 128;
    localparam int STACK_DEPTH = 8;
    // ------------------------------------------------------------
    // opcode groups and byte-oriented codes
    // ------------------------------------------------------------
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_CTL = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;
    localparam logic [3:0] OP_MISC = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_DECSZ = 4'hB;
    localparam logic [3:0] OP_RRC = 4'hC;
    localparam logic [3:0] OP_RLC = 4'hD;
    localparam logic [3:0] OP_SWAP = 4'hE;
    localparam logic [3:0] OP_INCSZ = 4'hF;
    localparam logic [7:0] MISC_RETURN = 8'h08;
    localparam logic [7:0] MISC_INT_RETURN = 8'h09;
    localparam logic [7:0] MISC_STANDBY = 8'h63;
    localparam logic [7:0] MISC_WATCHDOG = 8'h64;
    localparam logic [1:0] BIT_CLR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_TST_CLR = 2'h2;
    localparam logic [1:0] BIT_TST_SET = 2'h3;
    // literal sub-codes; add and subtract sit in bits 11..9, return and load in 11..10
    localparam logic [2:0] LIT_ADD = 3'h7;
    localparam logic [2:0] LIT_SUB = 3'h6;
    localparam logic [3:0] LIT_IOR = 4'h8;
    localparam logic [3:0] LIT_AND = 4'h9;
    localparam logic [3:0] LIT_XOR = 4'hA;
    localparam logic [1:0] LIT_RET = 2'h1;
    localparam logic [1:0] LIT_LOAD = 2'h0;
    // one instruction cycle is four clocks, gray along the path
    typedef enum logic [1:0] {
        Q0 = 2'h0,
        Q1 = 2'h1,
        Q2 = 2'h3,
        Q3 = 2'h2
    } mcuid_phase_t;
endpackage : mcuid_pkg
`default_nettype wire

// ### mcuid_core.sv
// Functional notes
// - 00 0111 adds accumulator and file, sets carry, digit carry, zero.
// - destination bit 0 writes accumulator, 1 writes the addressed file.
// - 00 0101 ands accumulator with file, only zero flag changes.
// - 00 0100 is or, 00 0110 is xor with file, zero flag.
// - 00 1101 rotates left, 00 1100 right, through carry only.
// - 00 1011 decrements file, zero result discards next instruction.
// - 00 1111 increments file, zero result skips next, flags kept.
// - bit words: 00 clear, 01 set, 10 test and skip if clear.
// - bit sub-op 11 skips next instruction when tested bit set.
// - 11 111x adds literal to accumulator with carry, digit carry, zero.
// - 11 1000 ors literal into accumulator, zero flag, one cycle.
// - 11 1010 xors literal into accumulator, zero flag.
// - 11 110x subtracts accumulator from literal, carry, digit carry, zero.
// - 11 01xx returns and loads literal into accumulator, two cycles.
// - call, jump and both returns take two cycles, second one idle.
// - standby and watchdog clear take one cycle, update timeout and powerdown.
// - port operated as function of itself reads pin levels.
// - byte write to timer zero clears prescaler when assigned.
// - one instruction cycle is four clocks.
// - seven bit file address selects one of 128 registers.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mcuid_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [12:0] pm_addr,
    input wire logic [13:0] pm_data,
    input wire logic [7:0] port_pins,
    output logic [7:0] port_latch,
    output logic prescaler_clr,
    output logic watchdog_clear,
    output logic standby
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mcuid_pkg::mcuid_phase_t q;
        logic [12:0] pc;
        logic [mcuid_pkg::STACK_DEPTH-1:0][12:0] stk;
        logic [2:0] sp;
        logic [mcuid_pkg::FILE_DEPTH-1:0][7:0] file;
        logic [7:0] acc;
        logic carry;
        logic digit_carry_flag;
        logic zero;
        logic timeout_flag;
        logic powerdown_flag_n;
        logic nop;
        logic hold;
        logic sleep;
        logic run;
        logic psa;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic pscl;
        logic wdtc;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [12:0] pm_addr;
    } mcuid_state_t;

    mcuid_state_t s;
    mcuid_state_t n;
    logic ex;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // adder giving {carry, digit carry, sum}; borrow is inverted carry
    function automatic logic [9:0] add_f(input logic [7:0] a, input logic [7:0] b,
                                         input logic ci);
        logic [8:0] sm;
        logic [4:0] hf;
        sm = {1'h0, a} + {1'h0, b} + {8'h00, ci};
        hf = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, ci};
        add_f = {sm[8], hf[4], sm[7:0]};
    endfunction : add_f

    // source operand; the port reads its pins, not its latch
    function automatic logic [7:0] rd_file(input mcuid_state_t st, input logic [6:0] a);
        rd_file = (a == mcuid_pkg::PORT_ADDR) ? st.pin_s2 : st.file[a];
    endfunction : rd_file

    assign ex = s.run & ~s.sleep & (s.q == mcuid_pkg::Q3);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [13:0] iw;
        logic [6:0] fa;
        logic [7:0] src;
        logic [7:0] res;
        logic [9:0] sum;
        logic wr;
        logic skip;
        iw = pm_data;
        fa = pm_data[6:0];
        src = rd_file(s, pm_data[6:0]);
        res = 8'h00;
        sum = 10'h000;
        wr = 1'b0;
        skip = 1'b0;
        n = s;
        n.pin_s1 = port_pins;
        n.pin_s2 = s.pin_s1;
        n.pscl = 1'b0;
        n.wdtc = 1'b0;
        // apb: answer in the access cycle, exactly one wait-free cycle
        n.pready = psel & ~penable;
        n.pslverr = 1'b0;
        n.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                mcuid_pkg::REG_CTRL: n.prdata = {30'h0, s.psa, s.run};
                mcuid_pkg::REG_STATUS: n.prdata = {26'h0, s.sleep, s.powerdown_flag_n,
                                                   s.timeout_flag, s.zero,
                                                   s.digit_carry_flag, s.carry};
                mcuid_pkg::REG_ACC: n.prdata = {24'h0, s.acc};
                mcuid_pkg::REG_PC: n.prdata = {19'h0, s.pc};
                default: n.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s.pready && pwrite && paddr == mcuid_pkg::REG_CTRL) begin
            n.run = pwdata[mcuid_pkg::CTRL_RUN_BIT];
            n.psa = pwdata[mcuid_pkg::CTRL_PSA_BIT];
            if (pwdata[mcuid_pkg::CTRL_WAKE_BIT]) begin
                n.sleep = 1'b0;
            end
        end
        // instruction phase; parked at q0 while stopped or asleep
        if (s.run && !s.sleep) begin
            case (s.q)
                mcuid_pkg::Q0: n.q = mcuid_pkg::Q1;
                mcuid_pkg::Q1: n.q = mcuid_pkg::Q2;
                mcuid_pkg::Q2: n.q = mcuid_pkg::Q3;
                default: n.q = mcuid_pkg::Q0;
            endcase
        end else begin
            n.q = mcuid_pkg::Q0;
        end
        // execute at the end of each instruction cycle
        if (ex && s.nop) begin
            // discarded slot: advance past a skipped word, hold after a branch
            n.nop = 1'b0;
            n.pc = s.hold ? s.pc : s.pc + 13'h0001;
        end else if (ex) begin
            n.pc = s.pc + 13'h0001;
            case (iw[13:12])
                mcuid_pkg::GRP_BYTE: begin
                    wr = 1'b1;
                    case (iw[11:8])
                        mcuid_pkg::OP_MISC: begin
                            wr = 1'b0;
                            if (iw[7]) begin
                                n.file[fa] = s.acc;
                                n.pscl = (fa == mcuid_pkg::TIMER_ZERO_ADDR) & s.psa;
                            end else begin
                                case (iw[7:0])
                                    mcuid_pkg::MISC_RETURN,
                                    mcuid_pkg::MISC_INT_RETURN: begin
                                        n.sp = s.sp - 3'h1;
                                        n.pc = s.stk[s.sp - 3'h1];
                                        n.nop = 1'b1;
                                        n.hold = 1'b1;
                                    end
                                    mcuid_pkg::MISC_STANDBY: begin
                                        n.timeout_flag = 1'b1;
                                        n.powerdown_flag_n = 1'b0;
                                        n.sleep = 1'b1;
                                        n.wdtc = 1'b1;
                                    end
                                    mcuid_pkg::MISC_WATCHDOG: begin
                                        n.timeout_flag = 1'b1;
                                        n.powerdown_flag_n = 1'b1;
                                        n.wdtc = 1'b1;
                                    end
                                    default: n.nop = 1'b0; // plain no-operation
                                endcase
                            end
                        end
                        mcuid_pkg::OP_CLR: begin
                            res = 8'h00;
                            n.zero = 1'b1;
                        end
                        mcuid_pkg::OP_SUB: begin
                            sum = add_f(src, ~s.acc, 1'b1);
                            res = sum[7:0];
                            n.carry = sum[9];
                            n.digit_carry_flag = sum[8];
                            n.zero = (sum[7:0] == 8'h00);
                        end
                        mcuid_pkg::OP_ADD: begin
                            sum = add_f(src, s.acc, 1'b0);
                            res = sum[7:0];
                            n.carry = sum[9];
                            n.digit_carry_flag = sum[8];
                            n.zero = (sum[7:0] == 8'h00);
                        end
                        mcuid_pkg::OP_AND: begin
                            res = src & s.acc;
                            n.zero = (res == 8'h00);
                        end
                        mcuid_pkg::OP_IOR, mcuid_pkg::OP_XOR: begin
                            res = (iw[11:8] == mcuid_pkg::OP_IOR) ? (src | s.acc)
                                                                   : (src ^ s.acc);
                            n.zero = (res == 8'h00);
                        end
                        mcuid_pkg::OP_DEC, mcuid_pkg::OP_INC,
                        mcuid_pkg::OP_COM, mcuid_pkg::OP_MOV: begin
                            case (iw[11:8])
                                mcuid_pkg::OP_DEC: res = src - 8'h01;
                                mcuid_pkg::OP_INC: res = src + 8'h01;
                                mcuid_pkg::OP_COM: res = ~src;
                                default: res = src;
                            endcase
                            n.zero = (res == 8'h00);
                        end
                        mcuid_pkg::OP_DECSZ: begin
                            res = src - 8'h01;
                            skip = (res == 8'h00);
                        end
                        mcuid_pkg::OP_INCSZ: begin
                            res = src + 8'h01;
                            skip = (res == 8'h00);
                        end
                        mcuid_pkg::OP_RLC: begin
                            res = {src[6:0], s.carry};
                            n.carry = src[7];
                        end
                        mcuid_pkg::OP_RRC: begin
                            res = {s.carry, src[7:1]};
                            n.carry = src[0];
                        end
                        default: res = {src[3:0], src[7:4]}; // swap, no flags
                    endcase
                    // clear-f and clear-w share a code, bit 7 picks the target
                    if (wr && iw[7]) begin
                        n.file[fa] = res;
                        n.pscl = (fa == mcuid_pkg::TIMER_ZERO_ADDR) & s.psa;
                    end else if (wr) begin
                        n.acc = res;
                    end
                end
                mcuid_pkg::GRP_BIT: begin
                    res = src;
                    case (iw[11:10])
                        mcuid_pkg::BIT_CLR: res[iw[9:7]] = 1'b0;
                        mcuid_pkg::BIT_SET: res[iw[9:7]] = 1'b1;
                        mcuid_pkg::BIT_TST_CLR: skip = ~src[iw[9:7]];
                        default: skip = src[iw[9:7]];
                    endcase
                    if (!iw[11]) begin
                        n.file[fa] = res;
                        n.pscl = (fa == mcuid_pkg::TIMER_ZERO_ADDR) & s.psa;
                    end
                end
                mcuid_pkg::GRP_CTL: begin
                    // call pushes the return address; stack wraps after eight
                    if (!iw[11]) begin
                        n.stk[s.sp] = s.pc + 13'h0001;
                        n.sp = s.sp + 3'h1;
                    end
                    n.pc = {s.pc[12:11], iw[10:0]};
                    n.nop = 1'b1;
                    n.hold = 1'b1;
                end
                default: begin
                    if (iw[11:9] == mcuid_pkg::LIT_ADD || iw[11:9] == mcuid_pkg::LIT_SUB) begin
                        // bit 9 tells add from subtract; subtract adds inverted acc plus one
                        sum = iw[9] ? add_f(iw[7:0], s.acc, 1'b0)
                                    : add_f(iw[7:0], ~s.acc, 1'b1);
                        n.acc = sum[7:0];
                        n.carry = sum[9];
                        n.digit_carry_flag = sum[8];
                        n.zero = (sum[7:0] == 8'h00);
                    end else if (iw[11:10] == mcuid_pkg::LIT_RET) begin
                        n.acc = iw[7:0];
                        n.sp = s.sp - 3'h1;
                        n.pc = s.stk[s.sp - 3'h1];
                        n.nop = 1'b1;
                        n.hold = 1'b1;
                    end else if (iw[11:10] == mcuid_pkg::LIT_LOAD) begin
                        n.acc = iw[7:0]; // load literal
                    end else begin
                        case (iw[11:8])
                            mcuid_pkg::LIT_IOR: begin
                                n.acc = iw[7:0] | s.acc;
                                n.zero = ((iw[7:0] | s.acc) == 8'h00);
                            end
                            mcuid_pkg::LIT_AND: begin
                                n.acc = iw[7:0] & s.acc;
                                n.zero = ((iw[7:0] & s.acc) == 8'h00);
                            end
                            mcuid_pkg::LIT_XOR: begin
                                n.acc = iw[7:0] ^ s.acc;
                                n.zero = ((iw[7:0] ^ s.acc) == 8'h00);
                            end
                            default: n.acc = iw[7:0]; // unlisted 11 1011 loads as well
                        endcase
                    end
                end
            endcase
            if (skip) begin
                n.nop = 1'b1;
                n.hold = 1'b0;
            end
        end
        n.pm_addr = n.pc;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset loads constants only; the file array starts cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.q <= mcuid_pkg::Q0;
            s.pc <= mcuid_pkg::PC_RESET;
            s.pm_addr <= mcuid_pkg::PC_RESET;
            s.run <= mcuid_pkg::CTRL_RUN_RESET;
            s.psa <= mcuid_pkg::CTRL_PSA_RESET;
            s.timeout_flag <= mcuid_pkg::TIMEOUT_RESET;
            s.powerdown_flag_n <= mcuid_pkg::POWERDOWN_N_RESET;
        end else begin
            s <= n;
        end
    end

    // outputs straight from state
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pm_addr = s.pm_addr;
    assign port_latch = s.file[mcuid_pkg::PORT_ADDR];
    assign prescaler_clr = s.pscl;
    assign watchdog_clear = s.wdtc;
    assign standby = s.sleep;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_phase_wrap: assert property (ex |=> s.q == mcuid_pkg::Q0)
        else $error("phase did not wrap after q3");
    a_pc_hold: assert property (!ex |=> $stable(s.pc))
        else $error("pc moved outside end of cycle");
    a_lit_add: assert property (ex && !s.nop && pm_data[13:9] == 5'h1F
        |=> s.acc == 8'($past(s.acc) + $past(pm_data[7:0])))
        else $error("literal add result wrong");
    a_lit_load: assert property (ex && !s.nop && pm_data[13:10] == 4'hC
        |=> s.acc == $past(pm_data[7:0]) && $stable(s.zero))
        else $error("literal load wrong");
    a_nop_slot: assert property (ex && s.nop |=> $stable(s.acc) && $stable(s.file))
        else $error("discarded slot changed state");
    a_jump_target: assert property (ex && !s.nop && pm_data[13:11] == 3'h5
        |=> s.pc[10:0] == $past(pm_data[10:0]) && s.nop && s.hold)
        else $error("jump target or idle slot wrong");
    a_standby_flags: assert property (ex && !s.nop && pm_data == 14'h0063
        |=> !s.powerdown_flag_n && s.timeout_flag && standby)
        else $error("standby flags wrong");
    a_pscl_cause: assert property (prescaler_clr |-> $past(ex) && $past(s.psa))
        else $error("prescaler cleared without timer write");
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb ready not a single pulse");
    c_call: cover property (ex && !s.nop && pm_data[13:11] == 3'h4);
    c_skip: cover property (ex && !s.nop ##4 ex && s.nop && !s.hold);
    c_standby: cover property (ex && pm_data == 14'h0063);
    c_pscl: cover property (prescaler_clr);
endmodule : mcuid_core
`default_nettype wire

// ### mcuid_pmem.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// program memory model, combinational read
// ----------------------------------------
module mcuid_pmem (
    input wire logic [12:0] pm_addr,
    output logic [13:0] pm_data
);
    logic [13:0] mem [0:63];
    // unloaded words stay zero, which decodes as a no-operation
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 14'h0000;
    end
    // word valid well before the end of q3 of its slot
    assign pm_data = mem[pm_addr[5:0]];
endmodule : mcuid_pmem
`default_nettype wire

// ### mcu_instruction_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decoder_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, port_pins, port_latch;
    logic [31:0] pwdata, prdata, q;
    logic [12:0] pm_addr;
    logic [13:0] pm_data;
    logic prescaler_clr, watchdog_clear, standby, e;
    int error_cnt = 0, num_checks = 0, pre_cnt = 0, wdc_cnt = 0;
    // ----------------------------------------
    // design, program memory and clock
    // ----------------------------------------
    mcuid_core u_mcuid_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data), .port_pins(port_pins),
        .port_latch(port_latch), .prescaler_clr(prescaler_clr),
        .watchdog_clear(watchdog_clear), .standby(standby));
    mcuid_pmem u_mcuid_pmem (.pm_addr(pm_addr), .pm_data(pm_data));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // one-cycle pulses are counted here so none is missed between reads
    always @(posedge pclk) begin
        if (prescaler_clr === 1'b1) pre_cnt <= pre_cnt + 1;
        if (watchdog_clear === 1'b1) wdc_cnt <= wdc_cnt + 1;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic wrap_up();
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench watchdog ends a stalled access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        port_pins = 8'hA5; presetn = 0;
        // program loaded after time zero, so the model's own clearing cannot race it
        repeat (4) @(posedge pclk);
        // pin read, latch write, timer write, flags, skips, jump, standby
        u_mcuid_pmem.mem[0] = 14'h0806; u_mcuid_pmem.mem[1] = 14'h0086;
        u_mcuid_pmem.mem[2] = 14'h0181; u_mcuid_pmem.mem[3] = 14'h300F;
        u_mcuid_pmem.mem[4] = 14'h3E01; u_mcuid_pmem.mem[5] = 14'h00A0;
        u_mcuid_pmem.mem[6] = 14'h07A0; u_mcuid_pmem.mem[7] = 14'h3AFF;
        u_mcuid_pmem.mem[8] = 14'h0520; u_mcuid_pmem.mem[9] = 14'h1421;
        u_mcuid_pmem.mem[10] = 14'h0BA1; u_mcuid_pmem.mem[11] = 14'h3AFF;
        u_mcuid_pmem.mem[12] = 14'h3801; u_mcuid_pmem.mem[13] = 14'h1EA0;
        u_mcuid_pmem.mem[14] = 14'h3AFF; u_mcuid_pmem.mem[15] = 14'h2811;
        u_mcuid_pmem.mem[16] = 14'h3AFF; u_mcuid_pmem.mem[17] = 14'h3C21;
        u_mcuid_pmem.mem[18] = 14'h0063; u_mcuid_pmem.mem[19] = 14'h2030;
        // after wake: call, rotates, swap, literal return, skips, watchdog clear
        u_mcuid_pmem.mem[20] = 14'h0FA1; u_mcuid_pmem.mem[21] = 14'h0421;
        u_mcuid_pmem.mem[22] = 14'h390F; u_mcuid_pmem.mem[23] = 14'h0221;
        u_mcuid_pmem.mem[24] = 14'h0081; u_mcuid_pmem.mem[25] = 14'h12A0;
        u_mcuid_pmem.mem[26] = 14'h1AA0; u_mcuid_pmem.mem[27] = 14'h3AFF;
        u_mcuid_pmem.mem[28] = 14'h0064; u_mcuid_pmem.mem[29] = 14'h2037;
        u_mcuid_pmem.mem[30] = 14'h281E; u_mcuid_pmem.mem[48] = 14'h3081;
        u_mcuid_pmem.mem[49] = 14'h00A2; u_mcuid_pmem.mem[50] = 14'h0DA2;
        u_mcuid_pmem.mem[51] = 14'h0CA2; u_mcuid_pmem.mem[52] = 14'h0E22;
        u_mcuid_pmem.mem[53] = 14'h0086; u_mcuid_pmem.mem[54] = 14'h345A;
        u_mcuid_pmem.mem[55] = 14'h0008;
        presetn <= 1'b1;
        apb(1'b0, mcuid_pkg::REG_STATUS, 32'h0);
        chk("status_rst", 32'h0000_0018, q);
        apb(1'b1, mcuid_pkg::REG_CTRL, 32'h0000_0003);
        repeat (150) @(posedge pclk);
        apb(1'b0, mcuid_pkg::REG_ACC, 32'h0);
        chk("acc", 32'h0000_0000, q);
        apb(1'b0, mcuid_pkg::REG_STATUS, 32'h0);
        chk("status", 32'h0000_002F, q);
        apb(1'b0, mcuid_pkg::REG_PC, 32'h0);
        chk("pc", 32'h0000_0013, q);
        chk("latch", 32'h0000_00A5, {24'h0, port_latch});
        chk("presc", 32'h1, pre_cnt);
        chk("wdclr", 32'h1, wdc_cnt);
        chk("standby", 32'h1, {31'h0, standby});
        apb(1'b1, mcuid_pkg::REG_CTRL, 32'h0000_0005);
        repeat (150) @(posedge pclk);
        chk("wake", 32'h0, {31'h0, standby});
        apb(1'b0, mcuid_pkg::REG_ACC, 32'h0);
        chk("acc2", 32'h0000_00F6, q);
        apb(1'b0, mcuid_pkg::REG_STATUS, 32'h0);
        chk("status2", 32'h0000_0018, q);
        apb(1'b0, mcuid_pkg::REG_PC, 32'h0);
        chk("pc2", 32'h0000_001E, q);
        chk("latch2", 32'h0000_0018, {24'h0, port_latch});
        chk("presc2", 32'h1, pre_cnt);
        chk("wdclr2", 32'h2, wdc_cnt);
        apb(1'b0, mcuid_pkg::REG_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0001, q);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        wrap_up();
    end
endmodule : mcu_instruction_decoder_tb
`default_nettype wire
